// ===== hw/oss_pkg.sv
// Purpose: constants shared by the oscillator source switch
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in the low byte
// Notes: register offsets are byte addresses
//
// Behaviour
// - source-rate clock follows the engaged source, one clk later
// - half-rate clock is source-rate clock halved
// - internal 12.8/8/4 MHz, 12.8 after reset
// - 8-bit signed trim, larger means slower
// - any non-internal source enables the input pin; crystal mode also drives the crystal output pin
// - two external rising edges confirm activity
// - set engaged first, then stop internal oscillator
// - clearing select and request returns to internal
// - direct external mode forces clock output enable off
// - crystal mode ignores clock output enable
// - rc mode drives clock out only when enabled
// - internal mode drives source clock when enabled
// - stop disables oscillators unless stop oscillator enable or run-in-stop set
// - clock output enable lives in pull register
// - source select encodings, reset to internal
// - internal frequency select encodings, reset 12.8
// - crystal range select chooses amplifier
// - request bit read/write, engaged bit read-only
package oss_pkg;

  // register byte offsets
  localparam logic [7:0] OSS_CTRL_OFS = 8'h00;
  localparam logic [7:0] OSS_TRIM_OFS = 8'h04;
  localparam logic [7:0] OSS_PULL_OFS = 8'h08;

  // control register fields
  localparam int OSS_SRC_LSB = 0;
  localparam int OSS_FREQ_LSB = 2;
  localparam int OSS_RANGE_LSB = 4;
  localparam int OSS_REQ_BIT = 6;
  localparam int OSS_ENG_BIT = 7;
  // pull register fields
  localparam int OSS_COE_BIT = 7;

  // source select codes
  localparam logic [1:0] OSS_SRC_INT = 2'h0;
  localparam logic [1:0] OSS_SRC_EXT = 2'h1;
  localparam logic [1:0] OSS_SRC_RC = 2'h2;
  localparam logic [1:0] OSS_SRC_XTAL = 2'h3;

  // internal frequency codes
  localparam logic [1:0] OSS_FREQ_4M0 = 2'h0;
  localparam logic [1:0] OSS_FREQ_8M0 = 2'h1;
  localparam logic [1:0] OSS_FREQ_12M8 = 2'h2;
  localparam logic [1:0] OSS_FREQ_RSVD = 2'h3;

  // reset values
  localparam logic [1:0] OSS_SRC_RST = OSS_SRC_INT;
  localparam logic [1:0] OSS_FREQ_RST = OSS_FREQ_12M8;
  localparam logic [1:0] OSS_RANGE_RST = 2'h0;
  localparam logic [7:0] OSS_TRIM_RST = 8'h00;
  localparam logic [7:0] OSS_PULL_RST = 8'h00;

  // activity check: rising edges of the external clock before switching
  localparam logic [1:0] OSS_EDGE_COUNT = 2'h2;

  // axi responses
  localparam logic [1:0] OSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] OSS_RESP_SLVERR = 2'h2;

  typedef enum {
    OSS_ST_INTERNAL,
    OSS_ST_CHECK,
    OSS_ST_EXTERNAL,
    OSS_ST_RETURN
  } oss_state_type;

endpackage

// ===== hw/oss_top.sv
// Purpose: clock source selection and glitch-free switching with register access
// Assumes: oscillator clocks and pins arrive sampled, synchronous to clk
// Notes: clocks are modelled as levels re-timed by clk; one clock domain
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module oss_top (
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // oscillator sources
  input wire logic internalSourceClock,
  input wire logic resistorCapClock,
  input wire logic crystalClock,
  input wire logic clockInPin,
  // stop control from system integration
  input wire logic stopMode,
  input wire logic stopOscillatorEnable,
  input wire logic runInStopOption,
  // clock outputs
  output logic sourceRateClock,
  output logic halfRateClock,
  // oscillator controls
  output logic internalOscRun,
  output logic rcOscRun,
  output logic crystalAmpRun,
  output logic [1:0] internalFreqSelect,
  output logic [1:0] crystalRangeSelect,
  output logic [7:0] trimValue,
  output logic [5:0] pullEnable,
  // pins
  output logic clockInPinEnable,
  output logic clockOutPinOut,
  output logic clockOutPinOe_n
);
  import oss_pkg::*;

  logic [1:0] sourceSelect_r;
  logic [1:0] freqSel_r;
  logic [1:0] rangeSel_r;
  logic extRequest_r;
  logic engaged_r;
  logic [7:0] trim_r;
  logic [7:0] pull_r;
  oss_state_type state_r;
  logic [1:0] edgeCnt_r;
  logic extPrev_r;
  logic intOsc_r;
  logic srcClk_r;
  logic halfClk_r;

  logic [7:0] awAddr_r;
  logic [7:0] wData_r;
  logic wStrb0_r;
  logic awHeld_r;
  logic wHeld_r;
  logic wrCommit;
  logic wrHit;
  logic [7:0] rdByte;
  logic rdHit;

  logic extSelClk;
  logic extRise;
  logic oscAllowed;
  logic coeEffective;

  // write takes effect once both address and data are held
  assign wrCommit = awHeld_r & wHeld_r & ~s_axi_bvalid;
  assign wrHit = (awAddr_r == OSS_CTRL_OFS) | (awAddr_r == OSS_TRIM_OFS) |
                 (awAddr_r == OSS_PULL_OFS);

  // write address and data channels, taken in either order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 8'h00;
      wStrb0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata[7:0];
        wStrb0_r <= s_axi_wstrb[0];
        wHeld_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrCommit) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
      end
      // ready again only after the response is taken: one write in flight
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= OSS_RESP_OKAY;
    end else if (wrCommit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? OSS_RESP_OKAY : OSS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read mux; upper 24 bits always read zero
  always_comb begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    case (s_axi_araddr)
      OSS_CTRL_OFS: begin
        rdByte[OSS_SRC_LSB +: 2] = sourceSelect_r;
        rdByte[OSS_FREQ_LSB +: 2] = freqSel_r;
        rdByte[OSS_RANGE_LSB +: 2] = rangeSel_r;
        rdByte[OSS_REQ_BIT] = extRequest_r;
        rdByte[OSS_ENG_BIT] = engaged_r;
      end
      OSS_TRIM_OFS: rdByte = trim_r;
      OSS_PULL_OFS: rdByte = pull_r;
      default: rdHit = 1'b0;
    endcase
  end

  // read channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= OSS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rdByte};
      s_axi_rresp <= rdHit ? OSS_RESP_OKAY : OSS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control register fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sourceSelect_r <= OSS_SRC_RST;
      freqSel_r <= OSS_FREQ_RST;
      rangeSel_r <= OSS_RANGE_RST;
      extRequest_r <= 1'b0;
    end else if (wrCommit && wStrb0_r && awAddr_r == OSS_CTRL_OFS) begin
      sourceSelect_r <= wData_r[OSS_SRC_LSB +: 2];
      freqSel_r <= wData_r[OSS_FREQ_LSB +: 2];
      rangeSel_r <= wData_r[OSS_RANGE_LSB +: 2];
      extRequest_r <= wData_r[OSS_REQ_BIT];
    end
  end

  // trim register, signed steps +127..-128, passed straight to the oscillator
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trim_r <= OSS_TRIM_RST;
    end else if (wrCommit && wStrb0_r && awAddr_r == OSS_TRIM_OFS) begin
      trim_r <= wData_r;
    end
  end

  // pull register holds the clock output enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pull_r <= OSS_PULL_RST;
    end else begin
      if (wrCommit && wStrb0_r && awAddr_r == OSS_PULL_OFS) begin
        pull_r <= wData_r;
      end
      // hardware clear wins so the pin is released for other functions
      if (sourceSelect_r == OSS_SRC_EXT) begin
        pull_r[OSS_COE_BIT] <= 1'b0;
      end
    end
  end

  // external source chosen by the select field
  always_comb begin
    case (sourceSelect_r)
      OSS_SRC_RC: extSelClk = resistorCapClock;
      OSS_SRC_XTAL: extSelClk = crystalClock;
      default: extSelClk = clockInPin;
    endcase
  end

  assign extRise = extSelClk & ~extPrev_r;
  // stop mode gates oscillators unless the stop oscillator enable or the run-in-stop option overrides
  assign oscAllowed = ~stopMode | stopOscillatorEnable | runInStopOption;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extPrev_r <= 1'b0;
    end else begin
      extPrev_r <= extSelClk;
    end
  end

  // switching sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= OSS_ST_INTERNAL;
      edgeCnt_r <= 2'h0;
      engaged_r <= 1'b0;
      intOsc_r <= 1'b1;
    end else begin
      case (state_r)
        OSS_ST_INTERNAL: begin
          intOsc_r <= 1'b1;
          edgeCnt_r <= 2'h0;
          if (extRequest_r && sourceSelect_r != OSS_SRC_INT) begin
            state_r <= OSS_ST_CHECK;
          end
        end
        OSS_ST_CHECK: begin
          if (!extRequest_r || sourceSelect_r == OSS_SRC_INT) begin
            state_r <= OSS_ST_INTERNAL;
          end else if (extRise) begin
            edgeCnt_r <= edgeCnt_r + 2'h1;
            if (edgeCnt_r + 2'h1 == OSS_EDGE_COUNT) begin
              engaged_r <= 1'b1;
              state_r <= OSS_ST_EXTERNAL;
            end
          end
        end
        OSS_ST_EXTERNAL: begin
          // internal oscillator stops only after engaged is already set
          intOsc_r <= 1'b0;
          if (!extRequest_r && sourceSelect_r == OSS_SRC_INT) begin
            intOsc_r <= 1'b1;
            state_r <= OSS_ST_RETURN;
          end
        end
        OSS_ST_RETURN: begin
          // internal oscillator ran one cycle before the mux moves back
          engaged_r <= 1'b0;
          state_r <= OSS_ST_INTERNAL;
        end
        default: state_r <= OSS_ST_INTERNAL;
      endcase
    end
  end

  // source-rate and half-rate clocks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      srcClk_r <= 1'b0;
      halfClk_r <= 1'b0;
    end else begin
      srcClk_r <= engaged_r ? extSelClk : (internalSourceClock & intOsc_r);
      if (srcClk_r == 1'b0 && (engaged_r ? extSelClk : (internalSourceClock & intOsc_r))) begin
        halfClk_r <= ~halfClk_r;
      end
    end
  end

  assign coeEffective = pull_r[OSS_COE_BIT];

  // oscillator enables, pin functions and settings towards the analog side
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      internalOscRun <= 1'b1;
      rcOscRun <= 1'b0;
      crystalAmpRun <= 1'b0;
      internalFreqSelect <= OSS_FREQ_RST;
      crystalRangeSelect <= OSS_RANGE_RST;
      trimValue <= OSS_TRIM_RST;
      pullEnable <= 6'h00;
      clockInPinEnable <= 1'b0;
      clockOutPinOut <= 1'b0;
      clockOutPinOe_n <= 1'b1;
    end else begin
      internalOscRun <= intOsc_r & oscAllowed;
      rcOscRun <= (sourceSelect_r == OSS_SRC_RC) & oscAllowed;
      crystalAmpRun <= (sourceSelect_r == OSS_SRC_XTAL) & oscAllowed;
      // reserved code falls back to the reset frequency
      internalFreqSelect <= (freqSel_r == OSS_FREQ_RSVD) ? OSS_FREQ_12M8 : freqSel_r;
      crystalRangeSelect <= rangeSel_r;
      trimValue <= trim_r;
      pullEnable <= pull_r[5:0];
      clockInPinEnable <= (sourceSelect_r != OSS_SRC_INT);
      case (sourceSelect_r)
        OSS_SRC_XTAL: begin
          clockOutPinOut <= ~clockInPin;
          clockOutPinOe_n <= 1'b0;
        end
        OSS_SRC_RC: begin
          clockOutPinOut <= srcClk_r;
          clockOutPinOe_n <= ~coeEffective;
        end
        OSS_SRC_INT: begin
          clockOutPinOut <= srcClk_r;
          clockOutPinOe_n <= ~coeEffective;
        end
        default: begin
          clockOutPinOut <= 1'b0;
          clockOutPinOe_n <= 1'b1;
        end
      endcase
    end
  end

  assign sourceRateClock = srcClk_r;
  assign halfRateClock = halfClk_r;

endmodule

`default_nettype wire

// ===== bench/oss_chk.sv
// Purpose: port checker for the oscillator source switch
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to oss_top by name
`timescale 1ns/1ns
`default_nettype none

module oss_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stopMode,
  input wire logic stopOscillatorEnable,
  input wire logic runInStopOption,
  input wire logic sourceRateClock,
  input wire logic halfRateClock,
  input wire logic internalOscRun,
  input wire logic rcOscRun,
  input wire logic crystalAmpRun,
  input wire logic [1:0] internalFreqSelect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // responses stand until the master takes them
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  // no new write taken while a response is pending
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted with response pending");
  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  // reserved code must never reach the oscillator
  freq_code_a: assert property (internalFreqSelect != 2'h3)
    else $error("reserved frequency code driven");
  stop_gate_a: assert property (stopMode && !stopOscillatorEnable &&
    !runInStopOption |=> !internalOscRun && !rcOscRun && !crystalAmpRun)
    else $error("oscillator left running in stop");
  // the half-rate clock only moves around a source-rate rising edge
  half_rate_a: assert property ($changed(halfRateClock) |->
    sourceRateClock || $past(sourceRateClock)) else $error("half-rate clock moved alone");
endmodule

bind oss_top oss_chk chk (.*);

`default_nettype wire

// ===== bench/oss_top_tb.sv
// Purpose: directed bench for the oscillator source switch
// Assumes: source clocks arrive as sampled levels re-timed by clk
// Notes: every wait is a bounded loop
`timescale 1ns/1ns
`default_nettype none

module oss_top_tb;
  import oss_pkg::*;
  logic clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, stopMode = 0, stopOscillatorEnable = 0;
  logic runInStopOption = 0, internalSourceClock = 0, resistorCapClock = 0;
  logic crystalClock = 0, clockInPin = 0, sourceRateClock, halfRateClock;
  logic internalOscRun, rcOscRun, crystalAmpRun, clockInPinEnable, clockOutPinOut;
  logic clockOutPinOe_n;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, trimValue;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, internalFreqSelect, crystalRangeSelect, r;
  logic [5:0] pullEnable;
  logic [3:0] cnt = 4'h0;
  int failCount = 0, testsRun = 0, i, n;

  oss_top uut (.*);

  always #5 clk = ~clk;
  // source clocks: internal at half the bench rate, externals slower
  always @(posedge clk) begin
    cnt <= cnt + 4'h1;
    internalSourceClock <= cnt[0];
    resistorCapClock <= cnt[1];
    crystalClock <= cnt[1];
    clockInPin <= cnt[1];
  end

  task automatic tally_and_finish;
    if (failCount == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      failCount++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rr);
    int k;
    k = 0;
    rr = 2'h1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) rr = s_axi_bresp;
    end while (!s_axi_bvalid && k < 40);
    s_axi_bready <= 1'b0;
    if (k >= 40) begin
      failCount++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
    int k;
    k = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 40);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 40) begin
      failCount++;
      tally_and_finish();
    end
  endtask

  // source-rate clock repeats the chosen source one clk later; half-rate
  // toggles once per source-rate rise, so 8 cycles give a known count
  task automatic src_chk(input logic useExt, input int halves);
    logic p;
    logic h;
    int t;
    t = 0;
    @(posedge clk);
    p = useExt ? clockInPin : internalSourceClock;
    h = halfRateClock;
    repeat (8) begin
      @(posedge clk);
      chk("srcclk", p, sourceRateClock);
      if (halfRateClock !== h) t++;
      h = halfRateClock;
      p = useExt ? clockInPin : internalSourceClock;
    end
    chk("halfclk", halves, t);
  endtask

  // main sequence
  initial begin
    idle(5);
    rst_n <= 1'b1;
    wr(8'h00, 32'h88, r); chk("bresp", OSS_RESP_OKAY, r);
    rd(8'h00, v, r); chk("ctrl", 32'h08, v);
    chk("rresp", OSS_RESP_OKAY, r);
    rd(8'h04, v, r); chk("trim", 32'h00, v);
    rd(8'h08, v, r); chk("pull", 32'h00, v);
    chk("freq", OSS_FREQ_12M8, internalFreqSelect);
    chk("irun", 1, internalOscRun);
    wr(8'h0c, 32'h5, r); chk("bresp", OSS_RESP_SLVERR, r);
    rd(8'h0c, v, r); chk("rresp", OSS_RESP_SLVERR, r);
    wr(8'h04, 32'h80, r); rd(8'h04, v, r); chk("trim", 32'h80, v);
    chk("trimv", 8'h80, trimValue);
    // a write without byte lane 0 leaves the register alone
    s_axi_wstrb <= 4'he;
    wr(8'h04, 32'h11, r);
    s_axi_wstrb <= 4'hf;
    rd(8'h04, v, r); chk("trim", 32'h80, v);
    src_chk(1'b0, 4);
    for (i = 0; i < 4; i++) begin
      wr(8'h00, i << 2, r); rd(8'h00, v, r); chk("ctrl", i << 2, v);
      idle(2); chk("freq", (i == 3) ? 2 : i, internalFreqSelect);
    end
    wr(8'h00, 32'h08, r); wr(8'h08, 32'h85, r);
    idle(2); chk("oe", 0, clockOutPinOe_n);
    chk("pins", 32'h05, pullEnable);
    @(posedge clk);
    v[0] = sourceRateClock;
    @(posedge clk);
    chk("pinclk", v[0], clockOutPinOut);
    wr(8'h00, 32'h0a, r); idle(2); chk("oe", 0, clockOutPinOe_n);
    chk("inen", 1, clockInPinEnable);
    chk("rcrun", 1, rcOscRun);
    wr(8'h08, 32'h00, r); idle(2); chk("oe", 1, clockOutPinOe_n);
    wr(8'h08, 32'h80, r); wr(8'h00, 32'h09, r);
    idle(2); rd(8'h08, v, r); chk("pull", 32'h00, v);
    chk("oe", 1, clockOutPinOe_n);
    // settling time before the request, as software must give it
    idle(16);
    wr(8'h00, 32'h49, r); n = 0;
    do begin rd(8'h00, v, r); n++; end while (!v[7] && n < 20);
    chk("ctrl", 32'hc9, v);
    idle(4); chk("irun", 0, internalOscRun);
    src_chk(1'b1, 2);
    wr(8'h00, 32'h08, r); n = 0;
    do begin rd(8'h00, v, r); n++; end while (v[7] && n < 20);
    chk("ctrl", 32'h08, v);
    idle(2); chk("irun", 1, internalOscRun);
    wr(8'h08, 32'h00, r); wr(8'h00, 32'h1b, r);
    idle(2); chk("oe", 0, clockOutPinOe_n);
    chk("range", 1, crystalRangeSelect);
    chk("xamp", 1, crystalAmpRun);
    @(posedge clk);
    v[0] = clockInPin;
    @(posedge clk);
    chk("xout", !v[0], clockOutPinOut);
    stopMode <= 1'b1; idle(3); chk("irun", 0, internalOscRun);
    chk("xamp", 0, crystalAmpRun);
    stopOscillatorEnable <= 1'b1; idle(3); chk("irun", 1, internalOscRun);
    stopOscillatorEnable <= 1'b0;
    runInStopOption <= 1'b1; idle(3); chk("irun", 1, internalOscRun);
    stopMode <= 1'b0;
    // reset again in mid-run: fields fall back to their reset values
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rd(8'h00, v, r); chk("ctrl", 32'h08, v);
    rd(8'h04, v, r); chk("trim", 32'h00, v);
    chk("freq", OSS_FREQ_12M8, internalFreqSelect);
    tally_and_finish();
  end
endmodule

`default_nettype wire
